// ==== common/adcwc_pkg.sv ====
package adcwc_pkg;

	////////////////////////////////////////////////////////////////////////
	// Sizes of the comparator unit.
	localparam int ADCWC_NUM_CMP = 8;
	localparam int ADCWC_NUM_SEQ = 4;
	localparam int ADCWC_NUM_STEP = 8;
	localparam int ADCWC_DATA_W = 10;
	localparam int ADCWC_ADDR_W = 8;
	localparam int ADCWC_REG_W = 32;

	////////////////////////////////////////////////////////////////////////
	// Register word addresses.
	localparam logic [7:0] ADCWC_OFS_CTRL = 8'h00;
	localparam logic [7:0] ADCWC_OFS_LIMITS = 8'h08;
	localparam logic [7:0] ADCWC_OFS_ROUTING = 8'h10;
	localparam logic [7:0] ADCWC_OFS_MASK = 8'h14;
	localparam logic [7:0] ADCWC_OFS_STATUS = 8'h15;

	// Field positions in the control word.
	localparam int ADCWC_IRQ_MODE_LSB = 0;
	localparam int ADCWC_IRQ_REGION_LSB = 2;
	localparam int ADCWC_IRQ_EN_BIT = 4;
	localparam int ADCWC_TRIG_MODE_LSB = 8;
	localparam int ADCWC_TRIG_REGION_LSB = 10;
	localparam int ADCWC_TRIG_EN_BIT = 12;

	// Field positions in the limits word and the status word.
	localparam int ADCWC_LOWER_LSB = 0;
	localparam int ADCWC_UPPER_LSB = 16;
	localparam int ADCWC_STAT_IRQ_LSB = 0;
	localparam int ADCWC_STAT_TRIG_LSB = 8;

	////////////////////////////////////////////////////////////////////////
	// Operating modes, region selects and one-hot bands.
	typedef enum logic [1:0] {
		ADCWC_MODE_ALWAYS = 2'h0,
		ADCWC_MODE_ONCE = 2'h1,
		ADCWC_MODE_HYST_ALWAYS = 2'h2,
		ADCWC_MODE_HYST_ONCE = 2'h3
	} adcwc_mode_t;

	localparam logic [1:0] ADCWC_REGION_LOW = 2'h0;
	localparam logic [1:0] ADCWC_REGION_MID = 2'h1;
	localparam logic [1:0] ADCWC_REGION_HIGH = 2'h3;

	localparam logic [2:0] ADCWC_BAND_LOW = 3'h1;
	localparam logic [2:0] ADCWC_BAND_MID = 3'h2;
	localparam logic [2:0] ADCWC_BAND_HIGH = 3'h4;

	// Hysteresis state of one output state machine.
	typedef enum logic [1:0] {
		ADCWC_HYST_CLEAR = 2'b01,
		ADCWC_HYST_SET = 2'b10
	} adcwc_hyst_t;

	////////////////////////////////////////////////////////////////////////
	// Carriers.
	typedef struct packed {
		logic trig_enable;
		logic [1:0] trig_region;
		logic [1:0] trig_mode;
		logic irq_enable;
		logic [1:0] irq_region;
		logic [1:0] irq_mode;
	} adcwc_ctrl_t;

	typedef struct packed {
		logic valid;
		logic [$clog2(ADCWC_NUM_SEQ)-1:0] seq;
		logic [$clog2(ADCWC_NUM_STEP)-1:0] step;
		logic [$clog2(ADCWC_NUM_CMP)-1:0] cmp;
		logic [ADCWC_DATA_W-1:0] data;
	} adcwc_conv_t;

	// Reset values.
	localparam adcwc_ctrl_t ADCWC_CTRL_RST = '0;
	localparam logic [ADCWC_DATA_W-1:0] ADCWC_LIMIT_RST = 10'h000;
	localparam logic [ADCWC_NUM_STEP-1:0] ADCWC_ROUTING_RST = 8'h00;
	localparam logic [ADCWC_NUM_CMP-1:0] ADCWC_MASK_RST = 8'h00;

	// Sorts a code into the low, mid or high band.
	function automatic logic [2:0] adcwc_band(
		input logic [ADCWC_DATA_W-1:0] value,
		input logic [ADCWC_DATA_W-1:0] lower,
		input logic [ADCWC_DATA_W-1:0] upper
	);
		if (value <= lower) begin
			return ADCWC_BAND_LOW;
		end else if (value <= upper) begin
			return ADCWC_BAND_MID;
		end else begin
			return ADCWC_BAND_HIGH;
		end
	endfunction : adcwc_band

endpackage : adcwc_pkg

// ==== rtl/adcwc_fsm.sv ====
module adcwc_fsm import adcwc_pkg::*; (
	input wire logic ref_clk_in,
	input wire logic srst_in,
	input wire logic enable_in,
	input wire logic [1:0] mode_in,
	input wire logic [1:0] region_in,
	input wire logic sample_in,
	input wire logic [2:0] band_in,
	output logic out_out
);

	adcwc_hyst_t hyst_reg;
	adcwc_hyst_t hyst_next;
	logic prev_met_reg;
	logic prev_met_next;
	logic out_reg;
	logic out_next;
	logic met;
	logic opposite;

	////////////////////////////////////////////////////////////////////////
	// Band criterion and the band that clears hysteresis.
	assign met = (region_in == ADCWC_REGION_LOW && band_in == ADCWC_BAND_LOW)
		|| (region_in == ADCWC_REGION_MID && band_in == ADCWC_BAND_MID)
		|| (region_in == ADCWC_REGION_HIGH && band_in == ADCWC_BAND_HIGH);
	assign opposite =
		(region_in == ADCWC_REGION_LOW && band_in == ADCWC_BAND_HIGH)
		|| (region_in == ADCWC_REGION_HIGH && band_in == ADCWC_BAND_LOW);

	// Output and history move only on a conversion for this comparator, or clear while the function is disabled.
	always_comb begin
		hyst_next = hyst_reg;
		prev_met_next = prev_met_reg;
		out_next = out_reg;
		if (!enable_in) begin
			hyst_next = ADCWC_HYST_CLEAR;
			prev_met_next = 1'b0;
			out_next = 1'b0;
		end else if (sample_in) begin
			prev_met_next = met;
			if (met) begin
				hyst_next = ADCWC_HYST_SET;
			end else if (opposite) begin
				hyst_next = ADCWC_HYST_CLEAR;
			end
			case (mode_in)
				ADCWC_MODE_ALWAYS: begin
					out_next = met;
				end
				ADCWC_MODE_ONCE: begin
					out_next = met && !prev_met_reg;
				end
				ADCWC_MODE_HYST_ALWAYS: begin
					out_next = met
						|| (hyst_reg == ADCWC_HYST_SET && !opposite);
				end
				default: begin
					out_next = met && !prev_met_reg
						&& hyst_reg == ADCWC_HYST_CLEAR;
				end
			endcase
		end
	end

	// State registers; reset makes the next entry a fresh one.
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			hyst_reg <= ADCWC_HYST_CLEAR;
			prev_met_reg <= 1'b0;
			out_reg <= 1'b0;
		end else begin
			hyst_reg <= hyst_next;
			prev_met_reg <= prev_met_next;
			out_reg <= out_next;
		end
	end

	assign out_out = out_reg;

	////////////////////////////////////////////////////////////////////////
	// Checks on the output state machine.
	property p_once_edge;
		@(posedge ref_clk_in) disable iff (srst_in)
		(enable_in && sample_in && mode_in == ADCWC_MODE_ONCE)
		|=> out_out == ($past(met) && !$past(prev_met_reg));
	endproperty
	a_once_edge: assert property (p_once_edge)
		else $error("Once mode output wrong.");

	property p_hyst_always_hold;
		@(posedge ref_clk_in) disable iff (srst_in)
		(enable_in && sample_in && mode_in == ADCWC_MODE_HYST_ALWAYS
		&& hyst_reg == ADCWC_HYST_SET && !opposite) |=> out_out;
	endproperty
	a_hyst_always_hold: assert property (p_hyst_always_hold)
		else $error("Hysteresis-always output dropped early.");

	property p_hyst_once_block;
		@(posedge ref_clk_in) disable iff (srst_in)
		(enable_in && sample_in && mode_in == ADCWC_MODE_HYST_ONCE
		&& hyst_reg == ADCWC_HYST_SET) |=> !out_out;
	endproperty
	a_hyst_once_block: assert property (p_hyst_once_block)
		else $error("Hysteresis-once fired while set.");

	property p_hyst_clear;
		@(posedge ref_clk_in) disable iff (srst_in)
		(enable_in && sample_in && opposite)
		|=> hyst_reg == ADCWC_HYST_CLEAR ##1 1'b1;
	endproperty
	a_hyst_clear: assert property (p_hyst_clear)
		else $error("Opposite band did not clear hysteresis.");

	property p_high_always;
		@(posedge ref_clk_in) disable iff (srst_in)
		(enable_in && sample_in && mode_in == ADCWC_MODE_ALWAYS
		&& region_in == ADCWC_REGION_HIGH && band_in == ADCWC_BAND_HIGH)
		|=> out_out;
	endproperty
	a_high_always: assert property (p_high_always)
		else $error("High band conversion missed.");

	property p_disabled_quiet;
		@(posedge ref_clk_in) disable iff (srst_in)
		!enable_in |=> !out_out && hyst_reg == ADCWC_HYST_CLEAR;
	endproperty
	a_disabled_quiet: assert property (p_disabled_quiet)
		else $error("Disabled function drives its output.");

	property p_reset_fresh;
		@(posedge ref_clk_in)
		srst_in |=> !out_out && !prev_met_reg
		&& hyst_reg == ADCWC_HYST_CLEAR;
	endproperty
	a_reset_fresh: assert property (p_reset_fresh)
		else $error("History not cleared by reset.");

endmodule : adcwc_fsm

// ==== rtl/adcwc_top.sv ====
// Notes on behaviour
// - Eight comparators, each with its own lower and upper limits.
// - Per-step route bit sends a result to FIFO or to a comparator.
// - Interrupt and trigger machines run apart on the same conversion.
// - Interrupt fires when its enable, condition and mask bit are all set.
// - Trigger output asserts on its condition while its enable is set.
// - Interrupt and trigger each have their own mode field.
// - Always mode asserts for every conversion in the chosen band.
// - Once mode asserts only on entry into the band.
// - Hysteresis-always holds until the opposite band is entered.
// - Hysteresis-once asserts on entry only while hysteresis is clear.
// - Hysteresis is for low or high band; opposite band clears it.
// - Low is at most lower limit, high above upper, mid between.
// - Region select 0x0 picks the low band.
// - Region select 0x1 picks the mid band, Always or Once only.
// - Region select 0x3 picks the high band, any mode.
// - Codes and limits are 10-bit unsigned values.
module adcwc_top import adcwc_pkg::*; #(
	parameter int NUM_CMP = ADCWC_NUM_CMP,
	parameter int NUM_SEQ = ADCWC_NUM_SEQ
) (
	input wire logic ref_clk_in,
	input wire logic srst_in,
	input wire logic [ADCWC_ADDR_W-1:0] reg_addr_in,
	input wire logic [ADCWC_REG_W-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [ADCWC_REG_W-1:0] reg_rdata_out,
	input wire adcwc_conv_t conv_in,
	output adcwc_conv_t fifo_out,
	output logic [NUM_CMP-1:0] irq_out,
	output logic [NUM_CMP-1:0] trig_out
);

	////////////////////////////////////////////////////////////////////////
	// Address window ends; each base is aligned to its block size.
	localparam logic [7:0] CTRL_END = ADCWC_OFS_CTRL + 8'(NUM_CMP);
	localparam logic [7:0] LIMITS_END = ADCWC_OFS_LIMITS + 8'(NUM_CMP);
	localparam logic [7:0] ROUTING_END = ADCWC_OFS_ROUTING + 8'(NUM_SEQ);

	adcwc_ctrl_t cmp_control_reg [NUM_CMP];
	adcwc_ctrl_t cmp_control_next [NUM_CMP];
	logic [ADCWC_DATA_W-1:0] lower_limit_reg [NUM_CMP];
	logic [ADCWC_DATA_W-1:0] lower_limit_next [NUM_CMP];
	logic [ADCWC_DATA_W-1:0] upper_limit_reg [NUM_CMP];
	logic [ADCWC_DATA_W-1:0] upper_limit_next [NUM_CMP];
	logic [ADCWC_NUM_STEP-1:0] sequence_routing_reg [NUM_SEQ];
	logic [ADCWC_NUM_STEP-1:0] sequence_routing_next [NUM_SEQ];
	logic [NUM_CMP-1:0] irq_mask_reg;
	logic [NUM_CMP-1:0] irq_mask_next;
	logic [ADCWC_REG_W-1:0] rdata_reg;
	logic [ADCWC_REG_W-1:0] rdata_next;

	adcwc_conv_t fifo_reg;
	adcwc_conv_t fifo_next;
	logic [NUM_CMP-1:0] irq_reg;
	logic [NUM_CMP-1:0] irq_next;

	logic step_route_to_cmp;
	logic fwd_valid;
	logic [NUM_CMP-1:0] irq_raw;
	logic [NUM_CMP-1:0] trig_raw;
	logic [NUM_CMP-1:0] sample;
	logic [2:0] band [NUM_CMP];

	////////////////////////////////////////////////////////////////////////
	// Register writes.
	always_comb begin
		for (int i = 0; i < NUM_CMP; i++) begin
			cmp_control_next[i] = cmp_control_reg[i];
			lower_limit_next[i] = lower_limit_reg[i];
			upper_limit_next[i] = upper_limit_reg[i];
		end
		for (int s = 0; s < NUM_SEQ; s++) begin
			sequence_routing_next[s] = sequence_routing_reg[s];
		end
		irq_mask_next = irq_mask_reg;
		if (reg_wr_in) begin
			if (reg_addr_in >= ADCWC_OFS_CTRL && reg_addr_in < CTRL_END) begin
				// Separate mode fields for the two functions.
				cmp_control_next[reg_addr_in[2:0]].irq_mode =
					reg_wdata_in[ADCWC_IRQ_MODE_LSB +: 2];
				cmp_control_next[reg_addr_in[2:0]].irq_region =
					reg_wdata_in[ADCWC_IRQ_REGION_LSB +: 2];
				cmp_control_next[reg_addr_in[2:0]].irq_enable =
					reg_wdata_in[ADCWC_IRQ_EN_BIT];
				cmp_control_next[reg_addr_in[2:0]].trig_mode =
					reg_wdata_in[ADCWC_TRIG_MODE_LSB +: 2];
				cmp_control_next[reg_addr_in[2:0]].trig_region =
					reg_wdata_in[ADCWC_TRIG_REGION_LSB +: 2];
				cmp_control_next[reg_addr_in[2:0]].trig_enable =
					reg_wdata_in[ADCWC_TRIG_EN_BIT];
			end else if (reg_addr_in >= ADCWC_OFS_LIMITS
				&& reg_addr_in < LIMITS_END) begin
				lower_limit_next[reg_addr_in[2:0]] =
					reg_wdata_in[ADCWC_LOWER_LSB +: ADCWC_DATA_W];
				upper_limit_next[reg_addr_in[2:0]] =
					reg_wdata_in[ADCWC_UPPER_LSB +: ADCWC_DATA_W];
			end else if (reg_addr_in >= ADCWC_OFS_ROUTING
				&& reg_addr_in < ROUTING_END) begin
				sequence_routing_next[reg_addr_in[1:0]] =
					reg_wdata_in[ADCWC_NUM_STEP-1:0];
			end else if (reg_addr_in == ADCWC_OFS_MASK) begin
				irq_mask_next = reg_wdata_in[NUM_CMP-1:0];
			end
		end
	end

	// Read data stand for one cycle only; unmapped words read as zero.
	always_comb begin
		rdata_next = '0;
		if (reg_rd_in) begin
			if (reg_addr_in >= ADCWC_OFS_CTRL && reg_addr_in < CTRL_END) begin
				rdata_next[ADCWC_IRQ_MODE_LSB +: 2] =
					cmp_control_reg[reg_addr_in[2:0]].irq_mode;
				rdata_next[ADCWC_IRQ_REGION_LSB +: 2] =
					cmp_control_reg[reg_addr_in[2:0]].irq_region;
				rdata_next[ADCWC_IRQ_EN_BIT] =
					cmp_control_reg[reg_addr_in[2:0]].irq_enable;
				rdata_next[ADCWC_TRIG_MODE_LSB +: 2] =
					cmp_control_reg[reg_addr_in[2:0]].trig_mode;
				rdata_next[ADCWC_TRIG_REGION_LSB +: 2] =
					cmp_control_reg[reg_addr_in[2:0]].trig_region;
				rdata_next[ADCWC_TRIG_EN_BIT] =
					cmp_control_reg[reg_addr_in[2:0]].trig_enable;
			end else if (reg_addr_in >= ADCWC_OFS_LIMITS
				&& reg_addr_in < LIMITS_END) begin
				rdata_next[ADCWC_LOWER_LSB +: ADCWC_DATA_W] =
					lower_limit_reg[reg_addr_in[2:0]];
				rdata_next[ADCWC_UPPER_LSB +: ADCWC_DATA_W] =
					upper_limit_reg[reg_addr_in[2:0]];
			end else if (reg_addr_in >= ADCWC_OFS_ROUTING
				&& reg_addr_in < ROUTING_END) begin
				rdata_next[ADCWC_NUM_STEP-1:0] =
					sequence_routing_reg[reg_addr_in[1:0]];
			end else if (reg_addr_in == ADCWC_OFS_MASK) begin
				rdata_next[NUM_CMP-1:0] = irq_mask_reg;
			end else if (reg_addr_in == ADCWC_OFS_STATUS) begin
				rdata_next[ADCWC_STAT_IRQ_LSB +: NUM_CMP] = irq_raw;
				rdata_next[ADCWC_STAT_TRIG_LSB +: NUM_CMP] = trig_raw;
			end
		end
	end

	// Register file state.
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			for (int i = 0; i < NUM_CMP; i++) begin
				cmp_control_reg[i] <= ADCWC_CTRL_RST;
				lower_limit_reg[i] <= ADCWC_LIMIT_RST;
				upper_limit_reg[i] <= ADCWC_LIMIT_RST;
			end
			for (int s = 0; s < NUM_SEQ; s++) begin
				sequence_routing_reg[s] <= ADCWC_ROUTING_RST;
			end
			irq_mask_reg <= ADCWC_MASK_RST;
			rdata_reg <= '0;
		end else begin
			for (int i = 0; i < NUM_CMP; i++) begin
				cmp_control_reg[i] <= cmp_control_next[i];
				lower_limit_reg[i] <= lower_limit_next[i];
				upper_limit_reg[i] <= upper_limit_next[i];
			end
			for (int s = 0; s < NUM_SEQ; s++) begin
				sequence_routing_reg[s] <= sequence_routing_next[s];
			end
			irq_mask_reg <= irq_mask_next;
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata_out = rdata_reg;

	////////////////////////////////////////////////////////////////////////
	// Result routing: FIFO or comparator, chosen per step.
	assign step_route_to_cmp = sequence_routing_reg[conv_in.seq][conv_in.step];
	assign fwd_valid = conv_in.valid && step_route_to_cmp;

	always_comb begin
		fifo_next = conv_in;
		fifo_next.valid = conv_in.valid && !step_route_to_cmp;
	end

	// Masked interrupt lines toward the interrupt controller.
	always_comb begin
		irq_next = irq_raw & irq_mask_reg;
	end

	// Output registers.
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			fifo_reg <= '0;
			irq_reg <= '0;
		end else begin
			fifo_reg <= fifo_next;
			irq_reg <= irq_next;
		end
	end

	assign fifo_out = fifo_reg;
	assign irq_out = irq_reg;
	assign trig_out = trig_raw;

	////////////////////////////////////////////////////////////////////////
	// Eight comparators, each with an interrupt and a trigger machine.
	for (genvar g = 0; g < NUM_CMP; g++) begin : g_cmp
		// Full-width unsigned compare of code against both limits.
		assign band[g] = adcwc_band(conv_in.data, lower_limit_reg[g],
			upper_limit_reg[g]);
		assign sample[g] = fwd_valid && conv_in.cmp == 3'(g);

		// Both machines see the same sample and band.
		adcwc_fsm u_irq_fsm (
			.ref_clk_in(ref_clk_in),
			.srst_in(srst_in),
			.enable_in(cmp_control_reg[g].irq_enable),
			.mode_in(cmp_control_reg[g].irq_mode),
			.region_in(cmp_control_reg[g].irq_region),
			.sample_in(sample[g]),
			.band_in(band[g]),
			.out_out(irq_raw[g])
		);

		adcwc_fsm u_trig_fsm (
			.ref_clk_in(ref_clk_in),
			.srst_in(srst_in),
			.enable_in(cmp_control_reg[g].trig_enable),
			.mode_in(cmp_control_reg[g].trig_mode),
			.region_in(cmp_control_reg[g].trig_region),
			.sample_in(sample[g]),
			.band_in(band[g]),
			.out_out(trig_raw[g])
		);

		// Band boundaries for this comparator.
		property p_band_split;
			@(posedge ref_clk_in) disable iff (srst_in)
			sample[g] |-> band[g] == ((conv_in.data <= lower_limit_reg[g])
			? ADCWC_BAND_LOW : (conv_in.data <= upper_limit_reg[g])
			? ADCWC_BAND_MID : ADCWC_BAND_HIGH);
		endproperty
		a_band_split: assert property (p_band_split)
			else $error("Conversion sorted into wrong band.");

		// Low band in Always mode on the trigger path.
		property p_low_trig;
			@(posedge ref_clk_in) disable iff (srst_in)
			(sample[g] && cmp_control_reg[g].trig_enable
			&& cmp_control_reg[g].trig_mode == ADCWC_MODE_ALWAYS
			&& cmp_control_reg[g].trig_region == ADCWC_REGION_LOW
			&& conv_in.data <= lower_limit_reg[g]) |=> trig_out[g];
		endproperty
		a_low_trig: assert property (p_low_trig)
			else $error("Low band trigger missed.");

		// Mid band in Always mode on the interrupt path.
		property p_mid_irq;
			@(posedge ref_clk_in) disable iff (srst_in)
			(sample[g] && cmp_control_reg[g].irq_enable
			&& cmp_control_reg[g].irq_mode == ADCWC_MODE_ALWAYS
			&& cmp_control_reg[g].irq_region == ADCWC_REGION_MID
			&& band[g] == ADCWC_BAND_MID && irq_mask_reg[g])
			##1 irq_mask_reg[g] |=> irq_out[g];
		endproperty
		a_mid_irq: assert property (p_mid_irq)
			else $error("Mid band interrupt missed.");
	end

	////////////////////////////////////////////////////////////////////////
	// Checks on routing, masking and the Always-mode trigger hold.
	property p_route_split;
		@(posedge ref_clk_in) disable iff (srst_in)
		conv_in.valid |=> fifo_out.valid == !$past(step_route_to_cmp)
		&& (fifo_out.data == $past(conv_in.data) || !fifo_out.valid);
	endproperty
	a_route_split: assert property (p_route_split)
		else $error("Conversion routed to the wrong place.");

	property p_irq_masked;
		@(posedge ref_clk_in) disable iff (srst_in)
		1'b1 |=> irq_out == ($past(irq_raw) & $past(irq_mask_reg));
	endproperty
	a_irq_masked: assert property (p_irq_masked)
		else $error("Interrupt not gated by its mask bit.");

	property p_always_trig;
		@(posedge ref_clk_in) disable iff (srst_in)
		(fwd_valid && cmp_control_reg[0].trig_enable
		&& cmp_control_reg[0].trig_mode == ADCWC_MODE_ALWAYS
		&& conv_in.cmp == 3'h0 && cmp_control_reg[0].trig_region
		== ADCWC_REGION_HIGH && conv_in.data > upper_limit_reg[0]
		&& conv_in.data > lower_limit_reg[0]) ##1 !fwd_valid [*2]
		|-> trig_out[0] && $stable(trig_out[0]);
	endproperty
	a_always_trig: assert property (p_always_trig)
		else $error("Always-mode trigger not held to next conversion.");

endmodule : adcwc_top

// ==== dv/adcwc_seq_model.sv ====
module adcwc_seq_model import adcwc_pkg::*; (
	output adcwc_conv_t conv_out
);
	timeunit 1ns;
	timeprecision 1ps;

	////////////////////////////////////////////////////////////////////////
	// The sequencer side starts idle with no conversion pending.
	initial begin
		conv_out = '0;
	end

	// Presents one conversion for the cycle after the call.
	task automatic send(input adcwc_conv_t c);
		conv_out <= c;
	endtask : send

	// Between conversions the stale fields are inverted so no old code lingers.
	task automatic idle();
		conv_out <= {1'b0, ~conv_out[$bits(adcwc_conv_t)-2:0]};
	endtask : idle
endmodule : adcwc_seq_model

// ==== dv/adcwc_top_tb.sv ====
module adcwc_top_tb import adcwc_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;

	logic ref_clk_in, srst_in, reg_wr_in, reg_rd_in;
	logic [7:0] reg_addr_in, irq, trig, mask, exp_irq;
	logic [31:0] reg_wdata_in, reg_rdata_out;
	adcwc_conv_t conv, fifo;
	logic [12:0] ctl [8];
	logic [9:0] lo [8], hi [8];
	logic [7:0] rt [4], em [2];
	logic [1:0] st [2][8];
	int err_count, comparisons, cycles;

	adcwc_top adcwc_top_i (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
		.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .conv_in(conv), .fifo_out(fifo),
		.irq_out(irq), .trig_out(trig));
	adcwc_seq_model adcwc_seq_model_i (.conv_out(conv));

	////////////////////////////////////////////////////////////////////////
	// Clock at 100 MHz and a cycle limit that cuts a hang short.
	initial begin
		ref_clk_in = 1'b0;
		forever #5 ref_clk_in = ~ref_clk_in;
	end
	always @(posedge ref_clk_in) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			report_and_stop();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Prints the counts and the verdict, then ends the run.
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : report_and_stop

	task automatic check(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask : check

	// Register bus cycles; read data are taken in the cycle after the strobe.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge ref_clk_in);
		reg_wr_in <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge ref_clk_in);
		reg_rd_in <= 1'b0;
		#1 d = reg_rdata_out;
	endtask : rd

	// Resets the unit and the bench's copy of every state machine.
	task automatic rst();
		@(posedge ref_clk_in);
		srst_in <= 1'b1;
		repeat (2) @(posedge ref_clk_in);
		srst_in <= 1'b0;
		@(posedge ref_clk_in);
		#1 check({16'h0, irq, trig}, 32'h0);
		em = '{default: 8'h0};
		st = '{default: '{default: 2'h0}};
	endtask : rst

	////////////////////////////////////////////////////////////////////////
	// Expected band, one-hot low, mid, high.
	function automatic logic [2:0] band(input logic [9:0] v, l, u);
		return (v <= l) ? 3'h1 : ((v <= u) ? 3'h2 : 3'h4);
	endfunction : band

	// Returns {output, previous met, hysteresis} for cfg = {region, mode}.
	function automatic logic [2:0] fsm(input logic [3:0] cfg,
		input logic [1:0] s, input logic [2:0] b);
		logic met, opp, o;
		met = (cfg[3:2] == 2'h0 && b[0]) || (cfg[3:2] == 2'h1 && b[1])
			|| (cfg[3:2] == 2'h3 && b[2]);
		opp = (cfg[3:2] == 2'h0 && b[2]) || (cfg[3:2] == 2'h3 && b[0]);
		case (cfg[1:0])
			2'h0: o = met;
			2'h1: o = met & !s[1];
			2'h2: o = met | (s[0] & !opp);
			default: o = met & !s[1] & !s[0];
		endcase
		return {o, met, met | (s[0] & !opp)};
	endfunction : fsm

	// Legal pairings only: hysteresis with low or high, mid with the rest.
	function automatic logic [3:0] pick(input int k);
		if (k < 8) return {k[2] ? 2'h3 : 2'h0, 2'(k)};
		return {2'h1, 1'b0, 1'(k)};
	endfunction : pick

	////////////////////////////////////////////////////////////////////////
	// Main sequence: register map, then random traffic per pairing set.
	initial begin
		logic [7:0] ra [6];
		logic [31:0] re [6], d;
		logic [2:0] r;
		adcwc_conv_t x, px, pc;
		int c;
		ra = '{8'h03, 8'h0B, 8'h11, 8'h14, 8'h15, 8'h20};
		re = '{32'h1F1F, 32'h03FF03FF, 32'hFF, 32'hFF, 32'h0, 32'h0};
		srst_in = 1'b1;
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		reg_addr_in = 8'h00;
		reg_wdata_in = 32'h0;
		void'($urandom(45446));
		rst();
		for (int i = 0; i < 6; i++) begin
			rd(ra[i], d);
			check(d, 32'h0);
			wr(ra[i], 32'hFFFFFFFF);
			rd(ra[i], d);
			check(d, re[i]);
		end
		$display("test register map done");
		for (int k = 0; k < 10; k++) begin
			rst();
			mask = 8'($urandom);
			wr(8'h14, {24'h0, mask});
			for (int n = 0; n < 8; n++) begin
				ctl[n] = {1'($urandom % 4 != 0), pick((k + n + 3) % 10), 3'h0,
					1'($urandom % 4 != 0), pick((k + n) % 10)};
				wr(8'(n), {19'h0, ctl[n]});
				lo[n] = 10'($urandom);
				hi[n] = (n == 0) ? lo[n] : lo[n] + 10'($urandom % (1024 - lo[n]));
				wr(8'(8 + n), {6'h0, hi[n], 6'h0, lo[n]});
			end
			for (int s = 0; s < 4; s++) begin
				rt[s] = 8'($urandom | $urandom);
				wr(8'(16 + s), {24'h0, rt[s]});
			end
			x = '0;
			// Scores the conversion taken at this edge while the next is sent.
			for (int t = 0; t <= 40; t++) begin
				px = x;
				pc = conv;
				x.valid = (t < 40) && ($urandom % 4 != 0);
				x.seq = 2'($urandom);
				x.step = 3'($urandom);
				x.cmp = 3'($urandom);
				c = x.cmp;
				case ($urandom % 4)
					0: x.data = lo[c];
					1: x.data = hi[c] + 10'h1;
					2: x.data = lo[c] + 10'h1;
					default: x.data = 10'($urandom);
				endcase
				if (x.valid) adcwc_seq_model_i.send(x);
				else adcwc_seq_model_i.idle();
				c = px.cmp;
				exp_irq = em[0] & mask;
				if (px.valid && rt[px.seq][px.step]) begin
					for (int f = 0; f < 2; f++) begin
						r = fsm(f ? ctl[c][11:8] : ctl[c][3:0], st[f][c],
							band(px.data, lo[c], hi[c]));
						if (!ctl[c][f ? 12 : 4]) r = 3'h0;
						em[f][c] = r[2];
						st[f][c] = r[1:0];
					end
				end
				#1 check({13'h0, fifo},
					{13'h0, px.valid & !rt[px.seq][px.step], pc[17:0]});
				check({24'h0, trig}, {24'h0, em[1]});
				check({24'h0, irq}, {24'h0, exp_irq});
				@(posedge ref_clk_in);
			end
			rd(8'h15, d);
			check(d, {16'h0, em[1], em[0]});
			$display("test pairing set %0d done", k);
		end
		report_and_stop();
	end
endmodule : adcwc_top_tb
